// file: logic/sscl_consts.vh
// Purpose: constants for the slave serial configuration loader
// Assumes: 40 MHz system clock, byte addresses on a plain register port
// Notes:   included by sscl_loader.v, the host model and the bench
//
// How it works
// - mode 111 selects host-clocked serial loading
// - one data bit taken per config_clock rise
// - mode pins sampled when init releases
// - done high frees mode and pull-up pins
// - pullup_disable steady; 0 pulls up, 1 not
// - init low while clearing, released after
// - crc mismatch drives init low
// - done low until successful completion
// - 300 ns low request restarts on rise
// - chained serial data forwarded on falls
// - mode 110 chain select after full load
// - mode 101 waits for test-port load only
// - test-access port enabled always
// - externally held init low stalls sequencer
// - tristate freed one clock, write one later
`ifndef SSCL_CONSTS_VH
`define SSCL_CONSTS_VH

// register byte offsets
`define SSCL_REG_STATUS   4'h0
`define SSCL_REG_MASK     4'h4
`define SSCL_REG_INFO     4'h8

// status and mask bit positions
`define SSCL_EV_CLEARED   0
`define SSCL_EV_CRC_ERR   1
`define SSCL_EV_DONE      2
`define SSCL_EV_RESTART   3
`define SSCL_EV_W         4

// mode codes
`define SSCL_MODE_SERIAL  3'h7
`define SSCL_MODE_PAR     3'h6
`define SSCL_MODE_JTAG    3'h5

// crc
`define SSCL_CRC_POLY     16'h8005
`define SSCL_CRC_INIT     16'hFFFF

// timing
`define SSCL_CLK_PERIOD_PS 25000
`define SSCL_PROG_MIN_NS   300
`define SSCL_PROG_MIN_CYC  ((`SSCL_PROG_MIN_NS * 1000 + `SSCL_CLK_PERIOD_PS - 1) / `SSCL_CLK_PERIOD_PS)

`endif

// file: logic/sscl_loader.v
// Purpose: device-side configuration sequencer for host-clocked serial loading
// Assumes: config_clock is far slower than clk and is sampled, not used as a clock
// Notes:   open-drain pins are split into input, output and output enable
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`include "sscl_consts.vh"

module sscl_loader #(
    parameter CFG_BITS     = 1024,  // payload bits before the 16-bit crc
    parameter CLEAR_CYCLES = 64     // memory clearing time in clk cycles
) (
    input  wire        clk,
    input  wire        srst,
    input  wire        config_clock,
    input  wire        data_in,
    input  wire        program_request_n,
    input  wire [2:0]  mode_sel,
    input  wire        pullup_disable,
    input  wire        read_write_n,
    input  wire        jtag_load_done,
    input  wire        init_in,
    output reg         init_out,
    output reg         init_oe,
    input  wire        done_in,
    output reg         done_out,
    output reg         done_oe,
    output reg         data_out,
    output reg         chain_select_out_n,
    output reg         pullup_enable,
    output reg         user_pins_free,
    output reg         global_output_tristate,
    output reg         global_write_enable,
    output reg         tap_enable,
    output reg         irq,
    input  wire [3:0]  addr,
    input  wire [31:0] wdata,
    input  wire        wr,
    input  wire        rd,
    output reg  [31:0] rdata
);

////////////////////////////////////////////////////////////////////////////////
// states

localparam [2:0] ST_CLEAR = 3'h0;  // clearing memory, init driven low
localparam [2:0] ST_WAIT  = 3'h1;  // waiting for the init line to go high
localparam [2:0] ST_LOAD  = 3'h2;  // taking payload bits
localparam [2:0] ST_CRC   = 3'h3;  // taking the trailing crc
localparam [2:0] ST_START = 3'h4;  // done released, start-up clocks
localparam [2:0] ST_USER  = 3'h5;  // user mode
localparam [2:0] ST_ERROR = 3'h6;  // crc failed, init held low
localparam [2:0] ST_JTAG  = 3'h7;  // waiting for test-port load

// the header count is a plain integer; only its low byte reaches the counter
localparam [31:0] PROG_MIN_W = `SSCL_PROG_MIN_CYC;  // 12 cycles at 40 MHz
localparam [7:0]  PROG_MIN   = PROG_MIN_W[7:0];     // cut to the low-time counter width

////////////////////////////////////////////////////////////////////////////////
// input synchronisers: two flops before any logic reads a pin

reg  [1:0] config_clock_s_q;     // config clock sync pair
reg        config_clock_d_q;     // delayed copy for edge finding
reg  [1:0] din_s_q;      // data sync pair, same depth as clock
reg  [1:0] prog_s_q;     // program request sync pair
reg        prog_d_q;     // delayed copy for the rise
reg  [1:0] init_s_q;     // init line sync pair
reg  [1:0] done_s_q;     // done line sync pair
reg  [5:0] mode_s1_q;    // mode, pull-up, rw first stage
reg  [5:0] mode_s2_q;    // second stage
reg  [1:0] jtag_s_q;     // test-port load finished sync pair

// all link pins share one depth so a data bit stays aligned with its clock edge
always @(posedge clk) begin
    if (srst) begin
        config_clock_s_q  <= 2'h0;
        config_clock_d_q  <= 1'b0;
        din_s_q   <= 2'h0;
        prog_s_q  <= 2'h3;
        prog_d_q  <= 1'b1;
        init_s_q  <= 2'h3;
        done_s_q  <= 2'h0;
        mode_s1_q <= 6'h00;
        mode_s2_q <= 6'h00;
        jtag_s_q  <= 2'h0;
    end else begin
        config_clock_s_q  <= {config_clock_s_q[0], config_clock};
        config_clock_d_q  <= config_clock_s_q[1];
        din_s_q   <= {din_s_q[0], data_in};
        prog_s_q  <= {prog_s_q[0], program_request_n};
        prog_d_q  <= prog_s_q[1];
        init_s_q  <= {init_s_q[0], init_in};
        done_s_q  <= {done_s_q[0], done_in};
        mode_s1_q <= {jtag_load_done, read_write_n, pullup_disable, mode_sel};
        mode_s2_q <= mode_s1_q;
        jtag_s_q  <= {jtag_s_q[0], mode_s1_q[5]};
    end
end

wire config_clock_rise = config_clock_s_q[1] & ~config_clock_d_q;
wire config_clock_fall = ~config_clock_s_q[1] & config_clock_d_q;
wire din_bit   = din_s_q[1];
wire prog_low  = ~prog_s_q[1];
wire prog_rise = prog_s_q[1] & ~prog_d_q;

////////////////////////////////////////////////////////////////////////////////
// program request pulse measurement

reg  [7:0] prog_cnt_q;   // low-time counter, saturates
reg        prog_long_q;  // low pulse reached the minimum

// even a short low glitch clears a loaded device; only the restart event needs the minimum
always @(posedge clk) begin
    if (srst) begin
        prog_cnt_q  <= 8'h00;
        prog_long_q <= 1'b0;
    end else if (prog_low) begin
        if (prog_cnt_q != 8'hFF)
            prog_cnt_q <= prog_cnt_q + 8'h01;
        if (prog_cnt_q >= PROG_MIN - 8'h01)
            prog_long_q <= 1'b1;
    end else begin
        prog_cnt_q <= 8'h00;
        if (prog_rise)
            prog_long_q <= 1'b0;
    end
end

// a short low pulse still clears, but raises no restart event
wire restart = prog_rise & prog_long_q;

////////////////////////////////////////////////////////////////////////////////
// sequencer

reg  [2:0]  state_q;     // sequencer state
reg  [31:0] cnt_q;       // clear timer, bit counter, start-up step
reg  [15:0] crc_q;       // running crc over payload
reg  [15:0] rx_crc_q;    // crc bits sent by the host
reg  [2:0]  mode_q;      // mode captured when init releases
reg         pud_q;       // pull-up control captured with the mode
reg         fwd_bit_q;   // bit waiting for the next fall
reg         ev_cleared;  // one-cycle event pulses
reg         ev_crc;
reg         ev_done;

// the check runs msb first over payload bits only, never over its own bits
wire [15:0] crc_next = {crc_q[14:0], 1'b0} ^
                       ((crc_q[15] ^ din_bit) ? `SSCL_CRC_POLY : 16'h0000);
wire [15:0] rx_next  = {rx_crc_q[14:0], din_bit};

// one process holds the whole configuration flow; a restart overrides all
always @(posedge clk) begin
    ev_cleared <= 1'b0;
    ev_crc     <= 1'b0;
    ev_done    <= 1'b0;
    if (srst || restart || prog_low) begin
        // held in clear while the request is low; counting starts on its rise
        state_q                <= ST_CLEAR;
        cnt_q                  <= 32'h0;
        crc_q                  <= `SSCL_CRC_INIT;
        rx_crc_q               <= 16'h0000;
        init_oe                <= 1'b1;
        done_oe                <= 1'b1;
        global_output_tristate <= 1'b1;
        global_write_enable    <= 1'b0;
        user_pins_free         <= 1'b0;
        data_out               <= 1'b0;
        fwd_bit_q              <= 1'b0;
        chain_select_out_n     <= 1'b1;
        if (srst) begin
            mode_q <= 3'h0;
            pud_q  <= 1'b0;
        end
    end else begin
        case (state_q)
            ST_CLEAR: begin
                // memory clearing keeps init low for a fixed time
                if (cnt_q == CLEAR_CYCLES - 1) begin
                    cnt_q   <= 32'h0;
                    init_oe <= 1'b0;
                    state_q <= ST_WAIT;
                end else begin
                    cnt_q <= cnt_q + 32'h1;
                end
            end
            ST_WAIT: begin
                // someone else may hold init low; stay until it reads high
                if (init_s_q[1]) begin
                    // mode and pull-up pins are taken as the line is seen high
                    mode_q     <= mode_s2_q[2:0];
                    pud_q      <= mode_s2_q[3];
                    ev_cleared <= 1'b1;
                    if (mode_s2_q[2:0] == `SSCL_MODE_JTAG)
                        state_q <= ST_JTAG;
                    else
                        state_q <= ST_LOAD;
                end
            end
            ST_LOAD: begin
                // only the serial code takes bits from the data pin
                if (config_clock_rise && mode_q == `SSCL_MODE_SERIAL) begin
                    crc_q <= crc_next;
                    if (cnt_q == CFG_BITS - 1) begin
                        cnt_q   <= 32'h0;
                        state_q <= ST_CRC;
                    end else begin
                        cnt_q <= cnt_q + 32'h1;
                    end
                end
                // parallel data path lives elsewhere; the hand-off needs rw low
                if (mode_q == `SSCL_MODE_PAR && jtag_s_q[1] && !mode_s2_q[4]) begin
                    chain_select_out_n <= 1'b0;
                    done_oe            <= 1'b0;
                    user_pins_free     <= 1'b1;
                    ev_done            <= 1'b1;
                    cnt_q              <= 32'h0;
                    state_q            <= ST_START;
                end
            end
            ST_CRC: begin
                if (config_clock_rise) begin
                    rx_crc_q <= rx_next;
                    if (cnt_q == 32'd15) begin
                        cnt_q <= 32'h0;
                        // the last check bit decides between done and error
                        if (rx_next == crc_q) begin
                            done_oe        <= 1'b0;
                            user_pins_free <= 1'b1;
                            ev_done        <= 1'b1;
                            state_q        <= ST_START;
                        end else begin
                            // init stays low until the host restarts
                            init_oe <= 1'b1;
                            ev_crc  <= 1'b1;
                            state_q <= ST_ERROR;
                        end
                    end else begin
                        cnt_q <= cnt_q + 32'h1;
                    end
                end
            end
            ST_START: begin
                // start-up steps advance on host clocks, hence the extra ones
                if (config_clock_rise) begin
                    // first rise frees the outputs, the second the writes
                    if (cnt_q == 32'h0) begin
                        global_output_tristate <= 1'b0;
                        cnt_q                  <= 32'h1;
                    end else begin
                        global_write_enable <= 1'b1;
                        user_pins_free      <= 1'b1;
                        state_q             <= ST_USER;
                    end
                end
            end
            ST_USER: begin
                // the state holds here until the next restart; serial forwarding still runs
                user_pins_free <= 1'b1;
            end
            ST_ERROR: begin
                // a crc failure is sticky: only a restart leaves it
                init_oe <= 1'b1;
            end
            ST_JTAG: begin
                // serial and parallel paths are ignored in this mode
                if (jtag_s_q[1]) begin
                    done_oe        <= 1'b0;
                    user_pins_free <= 1'b1;
                    ev_done <= 1'b1;
                    cnt_q   <= 32'h0;
                    state_q <= ST_START;
                end
            end
            default: begin
                state_q <= ST_CLEAR;
            end
        endcase
        // daisy chain: after own load, pass later bits on the falling edge
        if (mode_q == `SSCL_MODE_SERIAL && (state_q == ST_START || state_q == ST_USER)) begin
            if (config_clock_rise)
                fwd_bit_q <= din_bit;
            if (config_clock_fall)
                data_out <= fwd_bit_q;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// pin side outputs

// pull-ups follow the captured control until done frees the pin
// the test port never depends on the mode pins, so its enable is constant
always @(posedge clk) begin
    if (srst) begin
        init_out      <= 1'b0;
        done_out      <= 1'b0;
        pullup_enable <= 1'b1;
        tap_enable    <= 1'b1;
    end else begin
        init_out      <= 1'b0;  // open drain only ever pulls low
        done_out      <= 1'b0;
        pullup_enable <= ~user_pins_free & ~pud_q;
        tap_enable    <= 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////////////
// register port and interrupt

reg  [3:0] status_q;  // sticky events
reg  [3:0] mask_q;    // interrupt enables

wire [3:0] ev_set = {restart, ev_done, ev_crc, ev_cleared};
wire       wr_st  = wr && addr == `SSCL_REG_STATUS;

// write one clears; an event in the same cycle keeps its bit set
always @(posedge clk) begin
    if (srst) begin
        status_q <= 4'h0;
        mask_q   <= 4'h0;
        irq      <= 1'b0;
    end else begin
        status_q <= (status_q & ~(wr_st ? wdata[3:0] : 4'h0)) | ev_set;
        if (wr && addr == `SSCL_REG_MASK)
            mask_q <= wdata[3:0];
        irq <= |(status_q & mask_q);
    end
end

// read data stand one cycle after the strobe and are zero otherwise
// info shows state, captured mode and pull-up control, then both line levels
always @(posedge clk) begin
    if (srst || !rd) begin
        rdata <= 32'h0;
    end else begin
        case (addr)
            `SSCL_REG_STATUS: rdata <= {28'h0, status_q};
            `SSCL_REG_MASK:   rdata <= {28'h0, mask_q};
            `SSCL_REG_INFO:   rdata <= {22'h0, done_s_q[1], init_s_q[1], pud_q,
                                        mode_q, 1'b0, state_q};
            default:          rdata <= 32'h0;
        endcase
    end
end

endmodule // sscl_loader

// file: bench/sscl_loader_sva.sv
// Purpose: concurrent checks on the loader pins
// Assumes: single clk domain, srst synchronous active high
// Notes:   bound to every sscl_loader instance
`timescale 1ns/1ps
module sscl_loader_sva #(
    parameter CLEAR_CYCLES = 64  // clearing length, handed down by the bind
) (
    input wire        clk,
    input wire        srst,
    input wire        program_request_n,
    input wire        read_write_n,
    input wire        jtag_load_done,
    input wire        init_out,
    input wire        init_oe,
    input wire        done_out,
    input wire        done_oe,
    input wire        data_out,
    input wire        chain_select_out_n,
    input wire        user_pins_free,
    input wire        global_output_tristate,
    input wire        global_write_enable,
    input wire        tap_enable,
    input wire        rd,
    input wire [31:0] rdata
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////////////
    // how long init has been pulled low; saturates so it never wraps
    reg [7:0] hi_q;
    always @(posedge clk) begin
        if (srst || !init_oe) hi_q <= 8'h00;
        else if (hi_q != 8'hFF) hi_q <= hi_q + 8'h01;
    end
    ////////////////////////////////////////////////////////////////////////
    a_tap_on: assert property (tap_enable) else $error("test port disabled");
    a_od_low: assert property (!init_out && !done_out) else $error("open drain high");
    a_pins_free: assert property (user_pins_free |-> !done_oe) else $error("pins freed early");
    a_init_done: assert property (init_oe |-> done_oe) else $error("done with init low");
    a_prog_clear: assert property (!program_request_n [*6] |-> init_oe && done_oe)
        else $error("request did not restart");
    a_clear_len: assert property ($fell(init_oe) |-> hi_q >= CLEAR_CYCLES - 1)
        else $error("clearing too short");
    a_gts_late: assert property ($fell(global_output_tristate) |-> !$past(done_oe, 4))
        else $error("tristate freed too soon");
    a_gwe_late: assert property ($rose(global_write_enable) |-> !$past(global_output_tristate, 4))
        else $error("write enable too soon");
    a_fwd_after: assert property ($changed(data_out) |-> !done_oe || !$past(done_oe))
        else $error("forwarding before done");
    a_chain_sel: assert property ($fell(chain_select_out_n) |-> $past(jtag_load_done, 2) &&
        !$past(read_write_n, 2)) else $error("chain select without load");
    a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0) else $error("stray read data");
endmodule // sscl_loader_sva

bind sscl_loader sscl_loader_sva #(.CLEAR_CYCLES(CLEAR_CYCLES)) u_sva (
    .clk(clk), .srst(srst), .program_request_n(program_request_n), .read_write_n(read_write_n),
    .jtag_load_done(jtag_load_done), .init_out(init_out), .init_oe(init_oe),
    .done_out(done_out), .done_oe(done_oe), .data_out(data_out),
    .chain_select_out_n(chain_select_out_n), .user_pins_free(user_pins_free),
    .global_output_tristate(global_output_tristate),
    .global_write_enable(global_write_enable), .tap_enable(tap_enable), .rd(rd), .rdata(rdata));

// file: bench/sscl_host.sv
// Purpose: behavioural configuration host driving the serial link
// Assumes: link clock of 200 ns, made from 8 clk cycles
// Notes:   link clock rests low between bits; released data shows the inverse
`timescale 1ns/1ps
`include "sscl_consts.vh"
module sscl_host #(
    parameter N = 32  // payload bits per load
) (
    input  wire clk,
    output reg  config_clock,
    output reg  data_in,
    output reg  program_request_n
);
    reg [15:0] crc_q;  // running check value of the payload
    reg        fb;     // feedback bit of the check shift
    integer    k;
    initial begin
        config_clock = 1'b0;
        data_in = 1'b0;
        program_request_n = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////
    // restart: hold the request low for n clk cycles, then let it go
    task restart(input integer n);
        begin
            @(posedge clk);
            program_request_n <= 1'b0;
            repeat (n) @(posedge clk);
            program_request_n <= 1'b1;
        end
    endtask
    // one bit in 8 clk: data 3 clk ahead of the rise, held until the fall
    task send_bit(input b);
        begin
            @(posedge clk);
            data_in <= b;
            repeat (3) @(posedge clk);
            config_clock <= 1'b1;
            repeat (4) @(posedge clk);
            config_clock <= 1'b0;
            data_in <= ~b;  // hold over; a stale value must not be trusted
        end
    endtask
    // payload msb first, then the check value; bad flips its last bit
    task load(input [N-1:0] p, input bad);
        begin
            crc_q = `SSCL_CRC_INIT;
            for (k = N - 1; k >= 0; k = k - 1) begin
                send_bit(p[k]);
                fb = crc_q[15] ^ p[k];
                crc_q = {crc_q[14:0], 1'b0} ^ (fb ? `SSCL_CRC_POLY : 16'h0000);
            end
            for (k = 15; k >= 0; k = k - 1) begin
                send_bit(crc_q[k] ^ (bad && k == 0));
            end
        end
    endtask
endmodule // sscl_host

// file: bench/tb_slave_serial_config_loader.sv
// Purpose: self-checking bench for the serial configuration loader
// Assumes: 40 MHz clk, short payload and clearing counts for speed
// Notes:   init and done resolved here as pulled-up wired-and lines
`timescale 1ns/1ps
`include "sscl_consts.vh"
module tb_slave_serial_config_loader;
    reg         clk, srst, pullup_disable, read_write_n, jtag_load_done, ext_hold_n, wr, rd;
    reg  [2:0]  mode_sel;
    reg  [3:0]  addr;
    reg  [31:0] wdata;
    wire        config_clock, data_in, program_request_n, init_oe, done_oe, data_out;
    wire        chain_select_out_n, pullup_enable, user_pins_free, tap_enable, irq;
    wire        global_output_tristate, global_write_enable;
    wire        init_out, done_out;  // open-drain data, must never be high
    wire [31:0] rdata;
    integer     failures, n_tests, i;
    wire        init_in = ~init_oe & ext_hold_n;  // pull-up, device or board may pull low
    wire        done_in = ~done_oe;
    sscl_loader #(.CFG_BITS(32), .CLEAR_CYCLES(8)) uut (
        .clk(clk), .srst(srst), .config_clock(config_clock), .data_in(data_in),
        .program_request_n(program_request_n), .mode_sel(mode_sel),
        .pullup_disable(pullup_disable), .read_write_n(read_write_n),
        .jtag_load_done(jtag_load_done), .init_in(init_in), .init_out(init_out),
        .init_oe(init_oe), .done_in(done_in), .done_out(done_out), .done_oe(done_oe),
        .data_out(data_out),
        .chain_select_out_n(chain_select_out_n), .pullup_enable(pullup_enable),
        .user_pins_free(user_pins_free), .global_output_tristate(global_output_tristate),
        .global_write_enable(global_write_enable), .tap_enable(tap_enable), .irq(irq),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
    sscl_host #(.N(32)) host (.clk(clk), .config_clock(config_clock), .data_in(data_in),
        .program_request_n(program_request_n));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task give_verdict;
        begin
            if (failures == 0 && n_tests > 0) $display("TB: PASS");
            else $display("TB: FAIL");
            $finish;
        end
    endtask
    task chk(input [8*12-1:0] nm, input [31:0] e, input [31:0] g);
        begin
            n_tests = n_tests + 1;
            if (g !== e) begin
                failures = failures + 1;
                $display("[FAIL] %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    // wait n edges, then let their updates settle
    task settle(input integer n);
        begin
            repeat (n) @(posedge clk);
            #1;
        end
    endtask
    task wr_reg(input [3:0] a, input [31:0] d);
        begin
            @(posedge clk);
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
            @(posedge clk);
            wr <= 1'b0;
        end
    endtask
    // read data stands only in the cycle after the strobe
    task rd_chk(input [3:0] a, input [31:0] m, input [31:0] e);
        begin
            @(posedge clk);
            addr <= a;
            rd <= 1'b1;
            @(posedge clk);
            rd <= 1'b0;
            #1 chk("rdata", e, rdata & m);
        end
    endtask
    task wait_init;
        begin
            for (i = 0; i < 400 && init_in !== 1'b1; i = i + 1) @(posedge clk);
            if (init_in !== 1'b1) begin
                $display("[FAIL] init_in expected 1 seen %b", init_in);
                failures = failures + 1;
                give_verdict;
            end
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        srst = 1'b1; pullup_disable = 1'b0; read_write_n = 1'b1; jtag_load_done = 1'b0;
        ext_hold_n = 1'b1; wr = 1'b0; rd = 1'b0; mode_sel = `SSCL_MODE_SERIAL;
        addr = 4'h0; wdata = 32'h0; failures = 0; n_tests = 0;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        ext_hold_n <= 1'b0;
        settle(1);
        chk("init_oe", 1, init_oe);
        chk("pullup_en", 1, pullup_enable);
        chk("tap_en", 1, tap_enable);
        chk("init_out", 0, init_out);
        chk("done_out", 0, done_out);
        wr_reg(`SSCL_REG_MASK, 32'hF);
        rd_chk(4'hC, 32'hFFFFFFFF, 32'h0);
        settle(20);
        chk("init_oe", 0, init_oe);
        rd_chk(`SSCL_REG_INFO, 32'h7, 32'h1);
        ext_hold_n <= 1'b1;
        wait_init;
        mode_sel <= 3'h0;
        settle(2);
        rd_chk(`SSCL_REG_INFO, 32'hF0, 32'h70);
        chk("pullup_en", 1, pullup_enable);
        mode_sel <= `SSCL_MODE_SERIAL;
        host.load(32'hA5C30F96, 1'b0);
        settle(1);
        chk("done_oe", 0, done_oe);
        chk("pins_free", 1, user_pins_free);
        chk("pullup_en", 0, pullup_enable);
        chk("tristate", 1, global_output_tristate);
        host.send_bit(1'b1);
        settle(1);
        chk("tristate", 0, global_output_tristate);
        chk("write_en", 0, global_write_enable);
        host.send_bit(1'b0);
        settle(1);
        chk("write_en", 1, global_write_enable);
        chk("pins_free", 1, user_pins_free);
        chk("irq", 1, irq);
        rd_chk(`SSCL_REG_STATUS, 32'h7, 32'h5);
        wr_reg(`SSCL_REG_STATUS, 32'h5);
        settle(3);
        chk("irq", 0, irq);
        host.send_bit(1'b1);
        settle(5);
        chk("data_out", 1, data_out);
        host.send_bit(1'b0);
        settle(5);
        chk("data_out", 0, data_out);
        pullup_disable <= 1'b1;
        host.restart(12);
        settle(1);
        chk("done_oe", 1, done_oe);
        wait_init;
        host.load(32'h12345678, 1'b1);
        settle(2);
        chk("init_oe", 1, init_oe);
        chk("done_oe", 1, done_oe);
        chk("pullup_en", 0, pullup_enable);
        rd_chk(`SSCL_REG_STATUS, 32'hA, 32'hA);
        mode_sel <= `SSCL_MODE_JTAG;
        host.restart(12);
        wait_init;
        host.load(32'h0F0F0F0F, 1'b0);
        settle(2);
        chk("done_oe", 1, done_oe);
        jtag_load_done <= 1'b1;
        settle(8);
        chk("done_oe", 0, done_oe);
        jtag_load_done <= 1'b0;
        mode_sel <= `SSCL_MODE_PAR;
        read_write_n <= 1'b0;
        host.restart(12);
        wait_init;
        jtag_load_done <= 1'b1;
        settle(8);
        chk("chain_sel_n", 0, chain_select_out_n);
        give_verdict;
    end
endmodule // tb_slave_serial_config_loader
